// ### verilog/frsp_pkg.sv
// Purpose : shared constants and types of the flash row self-programming block
// Assumes : 32-bit APB register bus, 20 MHz system clock
// Notes   : byte offsets are word aligned

// ************************************************************
// package
// ************************************************************
package frsp_pkg;

   // ************************************************************
   // register map
   // ************************************************************
   localparam int           ADDR_W       = 8;
   localparam int           DATA_W       = 32;
   localparam logic [7:0]   OFS_CTRL     = 8'h00;
   localparam logic [7:0]   OFS_ADDR_LO  = 8'h04;
   localparam logic [7:0]   OFS_ADDR_HI  = 8'h08;
   localparam logic [7:0]   OFS_KEY      = 8'h0C;
   localparam logic [7:0]   OFS_TBL_PAGE = 8'h10;
   localparam logic [7:0]   OFS_TBL_EA   = 8'h14;
   localparam logic [7:0]   OFS_TBL_LOW  = 8'h18;
   localparam logic [7:0]   OFS_TBL_HIGH = 8'h1C;

   // ************************************************************
   // control fields
   // ************************************************************
   localparam int           CTRL_START_BIT = 15;
   localparam int           CTRL_WRITE_ENABLE_BIT_BIT  = 14;
   localparam int           CTRL_OP_W      = 7;
   localparam logic [6:0]   OP_ERASE_ROW   = 7'h41;
   localparam logic [6:0]   OP_PROG_ROW    = 7'h01;
   localparam logic [7:0]   KEY_FIRST      = 8'h55;
   localparam logic [7:0]   KEY_SECOND     = 8'hAA;

   // ************************************************************
   // geometry
   // ************************************************************
   localparam int           ROW_WORDS     = 32;
   localparam int           ROW_BYTES     = 96;
   localparam int           PANEL_ROWS    = 128;
   localparam int           WORD_W        = 24;
   localparam int           LOW_W         = 16;
   localparam int           HIGH_W        = 8;
   localparam int           ROW_ADDR_LSB  = 6;
   localparam logic [15:0]  EA_STEP       = 16'h0002;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [6:0]   OP_RST        = 7'h00;
   localparam logic [15:0]  ADDR_LO_RST   = 16'h0000;
   localparam logic [7:0]   ADDR_HI_RST   = 8'h00;
   localparam logic [7:0]   TBL_PAGE_RST  = 8'h00;
   localparam logic [15:0]  TBL_EA_RST    = 16'h0000;
   localparam logic [23:0]  LATCH_RST     = 24'hFFFFFF;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int           CLK_PERIOD_NS = 50;
   localparam int           OP_TIME_NS    = 2000000;
   localparam int           OP_CYCLES     =
      (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int           TABLE_WRITE_OP_CYCLES  = 2;

   // ************************************************************
   // states
   // ************************************************************
   typedef enum logic [1:0]
   {
      KEY_IDLE  = 2'b00,
      KEY_GOT55 = 2'b01,
      KEY_OPEN  = 2'b11
   } frsp_key_e;

   typedef enum logic
   {
      OP_IDLE = 1'b0,
      OP_RUN  = 1'b1
   } frsp_op_e;

endpackage : frsp_pkg

// ### verilog/frsp_latch_if.sv
// Purpose : write and read port of the row write latches
// Assumes : one system clock
// Notes   : plain signals, no clocking

`timescale 1ns/100ps

interface frsp_latch_if
#(
   parameter int WORDS = 32,
   parameter int WIDTH = 24
);
   localparam int IDX_W = $clog2(WORDS);

   logic             wr_low;
   logic             wr_high;
   logic [IDX_W-1:0] wr_idx;
   logic [15:0]      wr_data;
   logic [IDX_W-1:0] rd_idx;
   logic [WIDTH-1:0] rd_data;

   modport ctl
   (
      output wr_low,
      output wr_high,
      output wr_idx,
      output wr_data,
      output rd_idx,
      input  rd_data
   );

   modport bank
   (
      input  wr_low,
      input  wr_high,
      input  wr_idx,
      input  wr_data,
      input  rd_idx,
      output rd_data
   );

endinterface : frsp_latch_if

// ### verilog/frsp_latch_bank.sv
// Purpose : one row of instruction write latches in flip-flops
// Assumes : writes come from the table write path of the top
// Notes   : latches keep their data after a program cycle

`timescale 1ns/100ps

module frsp_latch_bank
   import frsp_pkg::*;
#(
   parameter int WORDS = ROW_WORDS
)
(
   input  wire logic   clk_sys,
   input  wire logic   rstn,
   input  wire logic   ce,
   frsp_latch_if.bank  lat
);

   logic [WORD_W-1:0] word_ff [WORDS];

   // the word index comes from fixed effective address bits
   if (WORDS != ROW_WORDS)
   begin : g_bad_words
      $error("frsp_latch_bank: WORDS must equal ROW_WORDS");
   end

   // ************************************************************
   // storage
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < WORDS; i++)
            word_ff[i] <= LATCH_RST;
      end
      else if (ce)
      begin
         if (lat.wr_low)
            word_ff[lat.wr_idx][LOW_W-1:0] <= lat.wr_data;
         if (lat.wr_high)
            word_ff[lat.wr_idx][WORD_W-1:LOW_W] <=
               lat.wr_data[HIGH_W-1:0];
      end
   end

   assign lat.rd_data = word_ff[lat.rd_idx];

endmodule : frsp_latch_bank

// ### verilog/frsp_top.sv
// Purpose : run-time self-programming sequencer for program flash rows
// Assumes : APB master on clk_sys; flash array logic on clk_sys
// Notes   : accesses are held off while an erase or program runs
//
// Summary of operation
// - a row is 32 instruction words of 24 bits, 96 bytes.
// - a panel holds 128 rows, 4K instruction words.
// - one operation erases one row or programs all 32 latched words.
// - 32-word write latches must be filled before programming starts.
// - each latch table write fills part of one word, taking 2 cycles.
// - control register selects erase or program and starts the cycle.
// - low address register captures table address bits 15:0, picks the row.
// - high address register captures table address bits 23:16.
// - software may write both address registers directly.
// - key register is write-only; 0x55 then 0xAA unlock a start.
// - an operation lasts about 2 ms and stalls the processor.
// - start bit 15 begins the operation and clears itself at the end.
// - program: set control, keys, start; hardware clears start bit.
// - high-byte latch writes keep only the low eight data bits.
// - table address is page bits 7:0 joined with the effective address.
// - low writes fill bits 15:0, high writes bits 23:16.
// - a start only takes effect when the same control write sets write enable (bit 14).
//
// Local design decisions: the register addresses and the APB slave port.

`timescale 1ns/100ps

module frsp_top
   import frsp_pkg::*;
#(
   parameter int OP_CNT = OP_CYCLES
)
(
   input  wire logic                clk_sys,
   input  wire logic                rstn,
   input  wire logic                ce,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic [DATA_W-1:0]   pwdata,
   output      logic [DATA_W-1:0]   prdata,
   output      logic                pready,
   output      logic                pslverr,
   output      logic                cpu_stall,
   output      logic                flash_erase,
   output      logic                flash_prog,
   output      logic [WORD_W-1:0]   flash_row_addr,
   input  wire logic [4:0]          flash_rd_idx,
   output      logic [WORD_W-1:0]   flash_rd_data
);

   localparam int CNT_W = $clog2(OP_CNT + 1);

   // ************************************************************
   // elaboration check
   // ************************************************************
   if (OP_CNT < 2)
   begin : g_bad_cnt
      $error("frsp_top: OP_CNT must be at least 2");
   end

   // a whole panel has to sit inside one table page of effective addresses
   if (PANEL_ROWS * ROW_WORDS * 2 > (1 << LOW_W))
   begin : g_bad_panel
      $error("frsp_top: panel does not fit one table page");
   end

   // ************************************************************
   // functions
   // ************************************************************
   function automatic logic op_valid(input logic [CTRL_OP_W-1:0] op);
      op_valid = (op == OP_ERASE_ROW) || (op == OP_PROG_ROW);
   endfunction : op_valid

   function automatic logic [WORD_W-1:0] row_base
   (
      input logic [7:0]  hi,
      input logic [15:0] lo
   );
      row_base = {hi, lo[15:ROW_ADDR_LSB], {ROW_ADDR_LSB{1'b0}}};
   endfunction : row_base

   // ************************************************************
   // state
   // ************************************************************
   frsp_key_e             key_st_ff;
   frsp_key_e             nxt_key_st;
   frsp_op_e              op_st_ff;
   logic [CNT_W-1:0]      cnt_ff;
   logic [1:0]            wait_ff;
   logic [1:0]            nxt_wait;
   logic                  write_enable_bit_ff;
   logic [CTRL_OP_W-1:0]  op_ff;
   logic [15:0]           addr_lo_ff;
   logic [7:0]            addr_hi_ff;
   logic [7:0]            tbl_page_ff;
   logic [15:0]           tbl_ea_ff;
   logic [DATA_W-1:0]     prdata_ff;
   logic                  pready_ff;
   logic                  pslverr_ff;
   logic                  stall_ff;
   logic                  erase_ff;
   logic                  prog_ff;
   logic [WORD_W-1:0]     row_ff;
   logic [WORD_W-1:0]     rd_data_ff;

   frsp_latch_if #(.WORDS(ROW_WORDS), .WIDTH(WORD_W)) lat_if ();

   frsp_latch_bank #(.WORDS(ROW_WORDS)) u_latch
   (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .ce      (ce),
      .lat     (lat_if.bank)
   );

   // ************************************************************
   // bus decode
   // ************************************************************
   wire hit_ctrl  = (paddr == OFS_CTRL);
   wire hit_lo    = (paddr == OFS_ADDR_LO);
   wire hit_hi    = (paddr == OFS_ADDR_HI);
   wire hit_key   = (paddr == OFS_KEY);
   wire hit_page  = (paddr == OFS_TBL_PAGE);
   wire hit_ea    = (paddr == OFS_TBL_EA);
   wire hit_tlow  = (paddr == OFS_TBL_LOW);
   wire hit_thigh = (paddr == OFS_TBL_HIGH);
   wire mapped    = hit_ctrl | hit_lo | hit_hi | hit_key | hit_page
                  | hit_ea | hit_tlow | hit_thigh;
   wire busy      = (op_st_ff == OP_RUN);
   wire acc       = ce & psel & penable;
   wire wr_acc    = acc & pready_ff & pwrite & mapped;
   wire tbl_wr    = pwrite & (hit_tlow | hit_thigh);
   // table writes hold the bus one cycle longer than register accesses
   wire [1:0] need_m1 = tbl_wr ? 2'(TABLE_WRITE_OP_CYCLES - 1) : 2'b00;
   // stalling pready while busy is what freezes the processor
   wire go_ans    = acc & ~pready_ff & ~busy & (wait_ff >= need_m1);

   assign nxt_wait = (go_ans | ~acc | pready_ff | busy) ? 2'b00
                   : 2'(wait_ff + 2'b01);

   // ************************************************************
   // read mux
   // ************************************************************
   // start bit reads back as the running operation
   wire [15:0] ctrl_rd = {busy, write_enable_bit_ff, 7'h00, op_ff};
   wire [DATA_W-1:0] rd_val =
        hit_ctrl ? {16'h0000, ctrl_rd}
      : hit_lo   ? {16'h0000, addr_lo_ff}
      : hit_hi   ? {24'h000000, addr_hi_ff}
      : hit_page ? {24'h000000, tbl_page_ff}
      : hit_ea   ? {16'h0000, tbl_ea_ff}
      : 32'h00000000; // key and table data ports read zero

   // ************************************************************
   // unlock and start
   // ************************************************************
   wire [7:0] key_in = pwdata[7:0];
   wire start_ok = wr_acc & hit_ctrl & pwdata[CTRL_START_BIT]
                 & (key_st_ff == KEY_OPEN)
                 & pwdata[CTRL_WRITE_ENABLE_BIT_BIT]
                 & op_valid(pwdata[CTRL_OP_W-1:0]);
   wire op_done  = busy & (cnt_ff == '0);

   // any other write to a mapped register between keys and start drops the unlock
   always_comb
   begin
      nxt_key_st = key_st_ff;
      if (wr_acc)
      begin
         if (hit_key && key_in == KEY_FIRST)
            nxt_key_st = KEY_GOT55;
         else if (hit_key && key_in == KEY_SECOND
                  && key_st_ff == KEY_GOT55)
            nxt_key_st = KEY_OPEN;
         else
            nxt_key_st = KEY_IDLE;
      end
   end

   // ************************************************************
   // table write path
   // ************************************************************
   // page joins the effective address; row word index is ea bits 5:1
   assign lat_if.wr_low  = wr_acc & hit_tlow;
   assign lat_if.wr_high = wr_acc & hit_thigh;
   assign lat_if.wr_idx  = tbl_ea_ff[ROW_ADDR_LSB-1:1];
   assign lat_if.wr_data = pwdata[15:0];
   assign lat_if.rd_idx  = flash_rd_idx;

   // ************************************************************
   // bus answer
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h00000000;
         wait_ff    <= 2'b00;
      end
      else if (ce)
      begin
         pready_ff  <= go_ans;
         pslverr_ff <= go_ans & ~mapped;
         prdata_ff  <= (go_ans & ~pwrite) ? rd_val : 32'h00000000;
         wait_ff    <= nxt_wait;
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         write_enable_bit_ff     <= 1'b0;
         op_ff       <= OP_RST;
         tbl_page_ff <= TBL_PAGE_RST;
         tbl_ea_ff   <= TBL_EA_RST;
         key_st_ff   <= KEY_IDLE;
      end
      else if (ce)
      begin
         key_st_ff <= nxt_key_st;
         if (wr_acc & hit_ctrl)
         begin
            write_enable_bit_ff <= pwdata[CTRL_WRITE_ENABLE_BIT_BIT];
            op_ff   <= pwdata[CTRL_OP_W-1:0];
         end
         if (wr_acc & hit_page)
            tbl_page_ff <= pwdata[7:0];
         if (wr_acc & hit_ea)
            tbl_ea_ff <= pwdata[15:0];
         else if (wr_acc & hit_thigh)
            tbl_ea_ff <= tbl_ea_ff + EA_STEP;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         addr_lo_ff <= ADDR_LO_RST;
         addr_hi_ff <= ADDR_HI_RST;
      end
      else if (ce)
      begin
         if (wr_acc & (hit_tlow | hit_thigh))
         begin
            addr_lo_ff <= tbl_ea_ff;
            addr_hi_ff <= tbl_page_ff;
         end
         else
         begin
            if (wr_acc & hit_lo)
               addr_lo_ff <= pwdata[15:0];
            if (wr_acc & hit_hi)
               addr_hi_ff <= pwdata[7:0];
         end
      end
   end

   // ************************************************************
   // operation timer
   // ************************************************************
   // writes of zero to the start bit never reach op_st_ff
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         op_st_ff <= OP_IDLE;
         cnt_ff   <= '0;
      end
      else if (ce)
      begin
         unique case (op_st_ff)
            OP_IDLE:
            begin
               if (start_ok)
               begin
                  op_st_ff <= OP_RUN;
                  cnt_ff   <= CNT_W'(OP_CNT - 1);
               end
            end
            OP_RUN:
            begin
               if (op_done)
                  op_st_ff <= OP_IDLE;
               else
                  cnt_ff <= cnt_ff - 1'b1;
            end
         endcase
      end
   end

   // ************************************************************
   // flash array side
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         stall_ff   <= 1'b0;
         erase_ff   <= 1'b0;
         prog_ff    <= 1'b0;
         row_ff     <= 24'h000000;
         rd_data_ff <= 24'h000000;
      end
      else if (ce)
      begin
         rd_data_ff <= lat_if.rd_data;
         if (start_ok)
         begin
            stall_ff <= 1'b1;
            erase_ff <= (pwdata[CTRL_OP_W-1:0] == OP_ERASE_ROW);
            prog_ff  <= (pwdata[CTRL_OP_W-1:0] == OP_PROG_ROW);
            row_ff   <= row_base(addr_hi_ff, addr_lo_ff);
         end
         else if (op_done)
         begin
            stall_ff <= 1'b0;
            erase_ff <= 1'b0;
            prog_ff  <= 1'b0;
         end
      end
   end

   assign prdata         = prdata_ff;
   assign pready         = pready_ff;
   assign pslverr        = pslverr_ff;
   assign cpu_stall      = stall_ff;
   assign flash_erase    = erase_ff;
   assign flash_prog     = prog_ff;
   assign flash_row_addr = row_ff;
   assign flash_rd_data  = rd_data_ff;

endmodule : frsp_top

// ### test/frsp_top_asserts.sv
// Purpose: port checks of the row self-programming sequencer
// Assumes: ce held high
// Notes  : op length is judged by a counter, not a long repetition
`timescale 1ns/100ps
// ****
// checker
// ****
module frsp_top_asserts
   import frsp_pkg::*;
#(
   parameter int OP_CNT = OP_CYCLES
)
(
   input wire logic                clk_sys,
   input wire logic                rstn,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [ADDR_W-1:0]   paddr,
   input wire logic [DATA_W-1:0]   pwdata,
   input wire logic [DATA_W-1:0]   prdata,
   input wire logic                pready,
   input wire logic                cpu_stall,
   input wire logic                flash_erase,
   input wire logic                flash_prog,
   input wire logic [WORD_W-1:0]   flash_row_addr
);
   int cnt_ff;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         cnt_ff <= 0;
      else
         cnt_ff <= cpu_stall ? cnt_ff + 1 : 0;
   end
   a_row_align: assert property (cpu_stall |->
      flash_row_addr[5:0] == 6'h00) else $error("row address not row aligned");
   a_one_op: assert property (!(flash_erase && flash_prog))
      else $error("erase and program together");
   a_stall_link: assert property (
      (flash_erase || flash_prog) == cpu_stall)
      else $error("stall does not follow operation");
   a_start_cause: assert property ($rose(cpu_stall) |-> $past(psel && penable
      && pready && pwrite && paddr == OFS_CTRL && pwdata[15] && pwdata[14]))
      else $error("operation began without a start write");
   a_erase_code: assert property ($rose(flash_erase) |->
      $past(pwdata[6:0]) == OP_ERASE_ROW) else $error("erase with wrong code");
   a_prog_code: assert property ($rose(flash_prog) |->
      $past(pwdata[6:0]) == OP_PROG_ROW) else $error("program with wrong code");
   a_busy_hold: assert property ($rose(cpu_stall) |-> !pready [*8])
      else $error("bus answered during operation");
   a_op_length: assert property ($fell(cpu_stall) |->
      cnt_ff >= OP_CNT - 1 && cnt_ff <= OP_CNT + 1)
      else $error("operation length wrong");
   a_tbl_wait: assert property ($rose(penable) && psel && pwrite && !cpu_stall
      && paddr == OFS_TBL_LOW |-> !pready ##1 !pready ##1 pready)
      else $error("table write not two waits");
   a_key_hidden: assert property (
      pready && !pwrite && paddr == OFS_KEY |-> prdata == 32'h0)
      else $error("key register readable");
endmodule : frsp_top_asserts
bind frsp_top frsp_top_asserts #(.OP_CNT(OP_CNT)) frsp_top_asserts_i
(
   .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .cpu_stall(cpu_stall), .flash_erase(flash_erase),
   .flash_prog(flash_prog), .flash_row_addr(flash_row_addr)
);

// ### test/frsp_flash_model.sv
// Purpose: flash array side, copies the latched row while programming
// Assumes: read data lags the index by one registered cycle
// Notes  : index wanders when idle so stale reads are not trusted
`timescale 1ns/100ps
// ****
// model
// ****
module frsp_flash_model
   import frsp_pkg::*;
(
   input  wire logic                clk_sys,
   input  wire logic                rstn,
   input  wire logic                flash_prog,
   input  wire logic [WORD_W-1:0]   flash_rd_data,
   output      logic [4:0]          flash_rd_idx,
   output      logic [WORD_W-1:0]   img [ROW_WORDS]
);
   int cnt;
   always @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt <= 0;
         flash_rd_idx <= 5'h00;
      end
      else if (!flash_prog)
      begin
         cnt <= 0;
         flash_rd_idx <= flash_rd_idx + 5'h03;
      end
      else if (cnt < ROW_WORDS + 2)
      begin
         flash_rd_idx <= 5'(cnt);
         if (cnt >= 2)
            img[cnt - 2] <= flash_rd_data;
         cnt <= cnt + 1;
      end
   end
endmodule : frsp_flash_model

// ### test/flash_row_self_programming_tb.sv
// Purpose: self-checking bench of the row self-programming sequencer
// Assumes: short op count so the run stays brief
// Notes  : reads are checked by a monitor against a queue of notes
`timescale 1ns/100ps
// ****
// bench
// ****
module flash_row_self_programming_tb;
   import frsp_pkg::*;
   localparam int OPN = 60;
   logic                clk_sys, rstn, ce, psel, penable, pwrite;
   logic [ADDR_W-1:0]   paddr;
   logic [DATA_W-1:0]   pwdata, prdata, r;
   logic                pready, pslverr, cpu_stall, flash_erase, flash_prog;
   logic [WORD_W-1:0]   flash_row_addr, flash_rd_data;
   logic [WORD_W-1:0]   img [ROW_WORDS];
   logic [WORD_W-1:0]   want [ROW_WORDS];
   logic [4:0]          flash_rd_idx;
   logic [32:0]         exp_q [$];
   logic [7:0]          page;
   logic [15:0]         ea;
   int                  err_count, n_compared, seed, i;
   frsp_top #(.OP_CNT(OPN)) frsp_top_i (.clk_sys(clk_sys), .rstn(rstn),
      .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cpu_stall(cpu_stall), .flash_erase(flash_erase),
      .flash_prog(flash_prog), .flash_row_addr(flash_row_addr),
      .flash_rd_idx(flash_rd_idx), .flash_rd_data(flash_rd_data));
   frsp_flash_model frsp_flash_model_i (.clk_sys(clk_sys), .rstn(rstn),
      .flash_prog(flash_prog), .flash_rd_data(flash_rd_data),
      .flash_rd_idx(flash_rd_idx), .img(img));
   task check(input logic [32:0] seen, input logic [32:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task end_of_test;
      if (err_count == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   // one idle edge after each transfer keeps drives apart
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask : apb
   task rd(input logic [7:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask : rd
   task unlock;
      apb(1'b1, OFS_KEY, 32'h55);
      apb(1'b1, OFS_KEY, 32'hAA);
   endtask : unlock
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      if (psel && penable && pready === 1'b1 && !pwrite)
         check({pslverr, prdata}, exp_q.pop_front());
   end
   initial
   begin
      #(50 * 40000);
      err_count++;
      end_of_test();
   end
   initial
   begin
      {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
      ce = 1'b1;
      seed = 32'h8FCFCCF6;
      err_count = 0;
      n_compared = 0;
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      rd(OFS_CTRL, 33'h0);
      rd(OFS_ADDR_LO, 33'h0);
      rd(8'h20, 33'h100000000);
      page = 8'($random(seed));
      ea = 16'($random(seed)) & 16'hFFC0;
      apb(1'b1, OFS_ADDR_LO, {16'h0, ~ea});
      apb(1'b1, OFS_ADDR_HI, {24'h0, ~page});
      rd(OFS_ADDR_LO, {17'h0, ~ea});
      rd(OFS_ADDR_HI, {25'h0, ~page});
      apb(1'b1, OFS_TBL_PAGE, {24'h0, page});
      apb(1'b1, OFS_TBL_EA, {16'h0, ea});
      for (i = 0; i < ROW_WORDS; i++)
      begin
         r = $random(seed);
         apb(1'b1, OFS_TBL_LOW, r);
         want[i][15:0] = r[15:0];
         r = $random(seed);
         apb(1'b1, OFS_TBL_HIGH, r);
         want[i][23:16] = r[7:0];
      end
      rd(OFS_TBL_EA, {17'h0, ea + 16'h0040});
      rd(OFS_ADDR_LO, {17'h0, ea + 16'h003E});
      rd(OFS_ADDR_HI, {25'h0, page});
      rd(OFS_KEY, 33'h0);
      unlock();
      apb(1'b1, OFS_CTRL, 32'hC001);
      repeat (2) @(posedge clk_sys);
      check({31'h0, cpu_stall, flash_prog}, 33'h3);
      check({9'h0, flash_row_addr}, {9'h0, page, ea[15:6], 6'h0});
      rd(OFS_CTRL, 33'h4001);
      for (i = 0; i < ROW_WORDS; i++)
         check({9'h0, img[i]}, {9'h0, want[i]});
      apb(1'b1, OFS_CTRL, 32'h4041);
      unlock();
      apb(1'b1, OFS_CTRL, 32'hC041);
      check({32'h0, flash_erase}, 33'h1);
      rd(OFS_CTRL, 33'h4041);
      // refused starts: no first key, stray write, no enable, bad key, bad op
      for (i = 0; i < 5; i++)
      begin
         if (i != 0)
            apb(1'b1, OFS_KEY, 32'h55);
         apb(1'b1, OFS_KEY, i == 3 ? 32'h5A : 32'hAA);
         if (i == 1)
            apb(1'b1, OFS_ADDR_LO, {16'h0, ea});
         apb(1'b1, OFS_CTRL,
             i == 2 ? 32'h8041 : i == 4 ? 32'hC002 : 32'hC041);
         check({32'h0, cpu_stall}, 33'h0);
      end
      rd(OFS_CTRL, 33'h4002);
      end_of_test();
   end
endmodule : flash_row_self_programming_tb
